// File: rtl/eeprom_defs.svh
/*
  Constants of the serial EEPROM address front end: clock rate, erase/write
  timing, memory geometry and code widths.
  Assumes inclusion by the package, the design modules and the testbench.
*/
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

`define CLK_MHZ       25
`define EW_TIME_US    10000
`define EXT_TICKS_DEF 16
`define EW_CNT_W      18
`define MEM_DEPTH     256
`define MEM_AW        8
`define DATA_W        8
`define CW_W          12
`define SYN_W         4
`define BIT_CNT_W     4
`define LAST_BIT      4'h7
`define SDA_LOW       1'b0
`define DEV_TYPE_DEF  4'h6

`endif

// File: rtl/eeprom_i2c_slave_select.sv
/*
  Address recognition front end of a small serial EEPROM on a two-wire bus,
  with the erase/write timer and the corrected storage array.
  Assumes the bus clock arrives on link_scl from the master, the data line
  is resolved outside from sda_oe, and straps are static after power-up.
*/
`timescale 1ns/100ps
`include "eeprom_defs.svh"

// Functional notes
// R1 - The top nibble of the address byte is a fixed device-type code, and only a match is taken.
// R2 - Address bits three to one are compared with the three select straps, highest strap first.
// R3 - A strap tied high reads as one and a strap tied low reads as zero.
// R4 - The address byte arrives most significant bit first with the direction bit last.
// R5 - The lowest address bit is one for a read and zero for a write.
// R6 - The device stores 256 bytes of eight bits reachable through the bus side; here the array is reached only through the wr_req and rd_req ports.
// R7 - Erase/write cycles are timed internally unless the external timing clock is chosen.
// R8 - Each byte is stored with a redundant code and a single-bit error is corrected on read.
// R9 - The master keeps its bus clock at or below one hundred kilohertz.
// R10 - While an erase/write cycle runs the device gives no acknowledge to its address.
// R11 - A non-matching address leaves the data line released and the rest is ignored until start.
module eeprom_i2c_slave_select #(
  parameter logic [3:0]  DEV_TYPE  = `DEV_TYPE_DEF,  // arbitrary value
  parameter int unsigned EW_CYCLES = `EW_TIME_US * `CLK_MHZ,
  parameter int unsigned EXT_TICKS = `EXT_TICKS_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               link_scl,
  input  wire logic               sda_in,
  output logic                    sda_out_ff,
  output logic                    sda_oe_ff,
  input  wire logic               select_strap_bit0,
  input  wire logic               select_strap_bit1,
  input  wire logic               select_strap_bit2,
  input  wire logic               program_timing_pin,
  input  wire logic               ext_timing_en,
  input  wire logic               wr_req,
  input  wire logic [`MEM_AW-1:0] wr_addr,
  input  wire logic [`DATA_W-1:0] wr_data,
  input  wire logic               rd_req,
  input  wire logic [`MEM_AW-1:0] rd_addr,
  output logic      [`DATA_W-1:0] rd_data_ff,
  output logic                    rd_valid_ff,
  output logic                    ew_busy_ff,
  output logic                    sel_match_ff,
  output logic                    rd_dir_ff,
  output eeprom_pkg::addr_s       addr_byte_ff
);
  import eeprom_pkg::*;

  // bus clock domain
  logic [`DATA_W-1:0]   shift_ff;
  logic [`DATA_W-1:0]   nxt_shift;
  logic                 tgl_ff;
  logic                 scl_seen_ff;
  // synchronisers
  pin_s                 raw;
  pin_s                 s1_ff, s2_ff, s3_ff, lvl_ff, lvl_d_ff;
  pin_s                 nxt_lvl;
  logic                 start_cond, stop_cond, bit_evt, scl_fall, tmg_rise;
  // link state
  link_state_e          st_ff, nxt_st;
  logic [`BIT_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                 nxt_oe, nxt_match, nxt_dir, nxt_sda_out, hit;
  addr_s                rx, nxt_addr_byte;
  // erase/write timer
  logic [`EW_CNT_W-1:0] ew_cnt_ff, nxt_ew_cnt;
  logic                 ew_ext_ff, nxt_ew_ext, nxt_busy, ew_tick, wr_go, rd_go;

  // address shift on each bus clock rise, with a toggle per bit
  assign nxt_shift = {shift_ff[`DATA_W-2:0], sda_in};  // R4

  always_ff @(posedge link_scl or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
      tgl_ff   <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      tgl_ff   <= ~tgl_ff;
    end
  end

  // assertion helper: marks the first bus clock rise out of reset
  always_ff @(posedge link_scl or negedge rst_n) begin
    if (!rst_n) scl_seen_ff <= 1'b0;
    else        scl_seen_ff <= 1'b1;
  end

  // slow inputs gathered for the three-stage synchroniser
  assign raw = '{bit_tgl: tgl_ff, ext_en: ext_timing_en, prog_tmg: program_timing_pin,
                 scl: link_scl, sda: sda_in,
                 strap: {select_strap_bit2, select_strap_bit1, select_strap_bit0}};

  // level moves only when stages two and three agree
  assign nxt_lvl = pin_s'(((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff));  // R3

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      lvl_ff   <= '0;
      lvl_d_ff <= '0;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      lvl_ff   <= nxt_lvl;
      lvl_d_ff <= lvl_ff;
    end
  end

  // bus conditions seen on the filtered levels
  assign start_cond = lvl_ff.scl && lvl_d_ff.scl && !lvl_ff.sda && lvl_d_ff.sda;
  assign stop_cond  = lvl_ff.scl && lvl_d_ff.scl && lvl_ff.sda && !lvl_d_ff.sda;
  assign bit_evt    = lvl_ff.bit_tgl != lvl_d_ff.bit_tgl;
  assign scl_fall   = !lvl_ff.scl && lvl_d_ff.scl;
  assign tmg_rise   = lvl_ff.prog_tmg && !lvl_d_ff.prog_tmg;
  // shift register is still between bus clock rises when the toggle lands
  assign rx         = addr_s'(shift_ff);
  assign hit        = (rx.dev_type == DEV_TYPE) && (rx.sel == lvl_ff.strap);  // R1 R2

  // link state machine: count bits, decode, drive or withhold acknowledge
  always_comb begin
    nxt_st        = st_ff;
    nxt_cnt       = cnt_ff;
    nxt_oe        = sda_oe_ff;
    nxt_match     = sel_match_ff;
    nxt_dir       = rd_dir_ff;
    nxt_addr_byte = addr_byte_ff;
    nxt_sda_out   = `SDA_LOW;
    if (start_cond) begin
      nxt_st    = ST_ADDR;
      nxt_cnt   = '0;
      nxt_oe    = 1'b0;
      nxt_match = 1'b0;
    end else if (stop_cond) begin
      nxt_st    = ST_IDLE;
      nxt_oe    = 1'b0;
      nxt_match = 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE, ST_IGNORE: nxt_oe = 1'b0;  // R11
        ST_ADDR: begin
          if (bit_evt) begin
            if (cnt_ff == `LAST_BIT) begin
              nxt_addr_byte = rx;
              nxt_match     = hit;  // R1 R2
              nxt_dir       = rx.rd;  // R5
              nxt_st        = (hit && !ew_busy_ff) ? ST_ACKWAIT : ST_IGNORE;  // R10 R11
            end else begin
              nxt_cnt = cnt_ff + `BIT_CNT_W'(1);
            end
          end
        end
        ST_ACKWAIT: begin
          // a write starting now would put the acknowledge inside its cycle
          if (ew_busy_ff || wr_req) nxt_st = ST_IGNORE;  // R10
          else if (scl_fall) begin
            nxt_oe = 1'b1;
            nxt_st = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0;
            nxt_st = ST_IGNORE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= ST_IDLE;
      cnt_ff       <= '0;
      sda_oe_ff    <= 1'b0;
      sda_out_ff   <= 1'b0;
      sel_match_ff <= 1'b0;
      rd_dir_ff    <= 1'b0;
      addr_byte_ff <= '0;
    end else begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      sda_oe_ff    <= nxt_oe;
      sda_out_ff   <= nxt_sda_out;
      sel_match_ff <= nxt_match;
      rd_dir_ff    <= nxt_dir;
      addr_byte_ff <= nxt_addr_byte;
    end
  end

  // erase/write timer: internal count or external timing clock edges
  assign wr_go   = wr_req && !ew_busy_ff;
  assign rd_go   = rd_req && !ew_busy_ff;
  assign ew_tick = ew_ext_ff ? tmg_rise : 1'b1;  // R7

  always_comb begin
    nxt_busy   = ew_busy_ff;
    nxt_ew_cnt = ew_cnt_ff;
    nxt_ew_ext = ew_ext_ff;
    if (!ew_busy_ff) begin
      if (wr_req) begin
        nxt_busy   = 1'b1;
        nxt_ew_cnt = '0;
        nxt_ew_ext = lvl_ff.ext_en;  // R7
      end
    end else if (ew_tick) begin
      if (ew_cnt_ff == `EW_CNT_W'((ew_ext_ff ? EXT_TICKS : EW_CYCLES) - 1)) nxt_busy = 1'b0;
      else nxt_ew_cnt = ew_cnt_ff + `EW_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ew_busy_ff  <= 1'b0;
      ew_cnt_ff   <= '0;
      ew_ext_ff   <= 1'b0;
      rd_valid_ff <= 1'b0;
    end else begin
      ew_busy_ff  <= nxt_busy;
      ew_cnt_ff   <= nxt_ew_cnt;
      ew_ext_ff   <= nxt_ew_ext;
      rd_valid_ff <= rd_go;
    end
  end

  // corrected storage array
  eeprom_store u_store (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_en      (wr_go),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .rd_en      (rd_go),
    .rd_addr    (rd_addr),
    .rd_data_ff (rd_data_ff)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_shift_msb_first: assert property (@(posedge link_scl) disable iff (!rst_n)
                     scl_seen_ff |-> shift_ff[`DATA_W-1:1] == $past(shift_ff[`DATA_W-2:0]))  // R4
    else $error("address bits not shifted msb first");
  a_match_type_code: assert property ($rose(sel_match_ff) |-> addr_byte_ff.dev_type == DEV_TYPE)  // R1
    else $error("match taken with wrong device type");
  a_match_strap_sel: assert property ($rose(sel_match_ff) |-> addr_byte_ff.sel == $past(lvl_ff.strap))  // R2
    else $error("match taken with wrong select bits");
  a_strap_level: assert property ((s2_ff.strap == s3_ff.strap) |=> lvl_ff.strap == $past(s3_ff.strap))  // R3
    else $error("strap level not following the pin");
  a_dir_from_lsb: assert property ($rose(sel_match_ff) |-> rd_dir_ff == addr_byte_ff.rd)  // R5
    else $error("direction differs from address lsb");
  a_busy_no_ack: assert property (ew_busy_ff |-> !$rose(sda_oe_ff))  // R10
    else $error("acknowledge given during erase/write");
  a_nomatch_quiet: assert property (!sel_match_ff |-> !sda_oe_ff)  // R11
    else $error("data line driven without a match");
  a_ew_internal_len: assert property ($rose(ew_busy_ff) && !ew_ext_ff |-> ew_busy_ff[*8])  // R7
    else $error("internal erase/write ended early");
  a_ew_ext_hold: assert property (ew_busy_ff && ew_ext_ff && !tmg_rise |=> ew_busy_ff)  // R7
    else $error("external erase/write ended without a timing edge");
  a_read_latency: assert property (rd_req && !ew_busy_ff |=> rd_valid_ff)  // R6
    else $error("read not answered in one cycle");

  c_ack_read:   cover property ($rose(sda_oe_ff) && rd_dir_ff);
  c_ack_write:  cover property ($rose(sda_oe_ff) && !rd_dir_ff);
  c_ignore:     cover property ($rose(st_ff == ST_IGNORE) && !sel_match_ff);
  c_ew_ext_end: cover property ($fell(ew_busy_ff) && ew_ext_ff);

endmodule : eeprom_i2c_slave_select

// File: rtl/eeprom_pkg.sv
/*
  Types shared by the EEPROM address front end and its storage array.
  Assumes the constants header is on the include path.
*/
`include "eeprom_defs.svh"

package eeprom_pkg;

  // link receiver states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACKWAIT, ST_ACK, ST_IGNORE} link_state_e;

  // slave address byte, first bit on the bus at the top
  typedef struct packed {
    logic [3:0] dev_type;
    logic [2:0] sel;
    logic       rd;
  } addr_s;

  // slow inputs that cross into the system clock
  typedef struct packed {
    logic       bit_tgl;
    logic       ext_en;
    logic       prog_tmg;
    logic       scl;
    logic       sda;
    logic [2:0] strap;
  } pin_s;

endpackage : eeprom_pkg

// File: rtl/eeprom_store.sv
/*
  256 x 8 storage kept as 12-bit single-error-correcting codewords.
  Assumes writes and reads come from logic on the same clock; read data
  is registered one cycle after the read request.
*/
`timescale 1ns/100ps
`include "eeprom_defs.svh"

module eeprom_store (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wr_en,
  input  wire logic [`MEM_AW-1:0]  wr_addr,
  input  wire logic [`DATA_W-1:0]  wr_data,
  input  wire logic                rd_en,
  input  wire logic [`MEM_AW-1:0]  rd_addr,
  output logic      [`DATA_W-1:0]  rd_data_ff
);
  import eeprom_pkg::*;

  logic [`CW_W-1:0]   mem_ff [`MEM_DEPTH];
  logic [`DATA_W-1:0] nxt_rd_data;
  logic               ecc_ok;

  // xor of the positions of all set bits
  function automatic logic [`SYN_W-1:0] ecc_syndrome(input logic [`CW_W-1:0] cw);
    logic [`SYN_W-1:0] syn;
    syn = '0;
    for (int i = 1; i <= `CW_W; i++) begin
      if (cw[i-1]) syn = syn ^ `SYN_W'(i);
    end
    return syn;
  endfunction : ecc_syndrome

  // data on non-power-of-two positions, parity on the rest
  function automatic logic [`CW_W-1:0] ecc_encode(input logic [`DATA_W-1:0] d);
    logic [`CW_W-1:0]  cw;
    logic [`SYN_W-1:0] syn;
    int                j;
    cw = '0;
    j  = 0;
    for (int i = 1; i <= `CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i-1] = d[j];
        j++;
      end
    end
    syn = ecc_syndrome(cw);
    for (int k = 0; k < `SYN_W; k++) cw[(1 << k) - 1] = syn[k];
    return cw;
  endfunction : ecc_encode

  // flip the bit the syndrome points at, then strip the parity
  function automatic logic [`DATA_W-1:0] ecc_decode(input logic [`CW_W-1:0] cw_in);
    logic [`CW_W-1:0]   cw;
    logic [`SYN_W-1:0]  syn;
    logic [`DATA_W-1:0] d;
    int                 j;
    cw  = cw_in;
    d   = '0;
    j   = 0;
    syn = ecc_syndrome(cw);
    if (syn != '0 && syn <= `SYN_W'(`CW_W)) cw[syn-1] = ~cw[syn-1];
    for (int i = 1; i <= `CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = cw[i-1];
        j++;
      end
    end
    return d;
  endfunction : ecc_decode

  // array write of the encoded byte
  always_ff @(posedge clk) begin
    if (wr_en) mem_ff[wr_addr] <= ecc_encode(wr_data);  // R6 R8
  end

  // corrected read data, held until the next read
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_en) nxt_rd_data = ecc_decode(mem_ff[rd_addr]);  // R8
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_data_ff <= '0;
    else        rd_data_ff <= nxt_rd_data;
  end

  // helper: every single-bit fault of the written word decodes back
  always_comb begin
    ecc_ok = 1'b1;
    for (int k = 0; k < `CW_W; k++) begin
      if (ecc_decode(ecc_encode(wr_data) ^ (`CW_W'(1) << k)) != wr_data) ecc_ok = 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ecc_single_fix: assert property (wr_en |-> ecc_ok)  // R8
    else $error("single-bit fault not corrected");
  a_ecc_clean_read: assert property (wr_en |=> ecc_decode(mem_ff[$past(wr_addr)]) == $past(wr_data))  // R6
    else $error("read after write returned wrong byte");

endmodule : eeprom_store

// File: sim/i2c_master_model.sv
/*
  Bus master model: bit-banged start, byte, acknowledge and stop.
  Assumes the bench resolves the data line with a pull-up; all moves
  land on falling edges of the system clock.
*/
`timescale 1ns/100ps

module i2c_master_model #(
  parameter int HALF = 125
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // bus idle: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // wait n falling edges of the system clock; HALF of them make one half period of a 100 kHz bus clock
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // data falls while clock is high
  task automatic start_cond();
    sda_low = 1'b1;
    wait_clk(HALF);
    scl = 1'b0;
  endtask : start_cond

  // eight bits msb first, then sample the acknowledge clock
  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(HALF / 2);
      sda_low = ~b[i];
      wait_clk(HALF - HALF / 2);
      scl = 1'b1;
      wait_clk(HALF);
      scl = 1'b0;
    end
    wait_clk(HALF / 2);
    sda_low = 1'b0;
    wait_clk(HALF - HALF / 2);
    scl = 1'b1;
    wait_clk(HALF / 2);
    ack_n = sda_line;
    wait_clk(HALF - HALF / 2);
    scl = 1'b0;
  endtask : send_byte

  // data rises while clock is high
  task automatic stop_cond();
    wait_clk(HALF / 2);
    sda_low = 1'b1;
    wait_clk(HALF - HALF / 2);
    scl = 1'b1;
    wait_clk(HALF);
    sda_low = 1'b0;
    wait_clk(HALF);
  endtask : stop_cond
endmodule : i2c_master_model

// File: sim/tb.sv
/*
  Testbench: address decode, erase/write timing and storage readback.
  Assumes the design package and header are compiled first.
*/
`timescale 1ns/100ps
`include "eeprom_defs.svh"

module tb;
  import eeprom_pkg::*;
  localparam logic [3:0] DEV = 4'h9; // arbitrary value
  logic       clk, rst_n, scl, sda_low, sda_line, tmg_pin, ext_en, wr_req, rd_req, ack_n;
  logic       sda_out_ff, sda_oe_ff, rd_valid_ff, ew_busy_ff, sel_match_ff, rd_dir_ff;
  logic [2:0] strap;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data_ff;
  addr_s      addr_byte_ff;
  int         error_cnt, comparisons, n;

  // system clock, 40 ns
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // open-drain data line with pull-up
  assign sda_line = ~(sda_low | (sda_oe_ff & ~sda_out_ff));

  eeprom_i2c_slave_select #(.DEV_TYPE(DEV), .EW_CYCLES(20), .EXT_TICKS(3))
    eeprom_i2c_slave_select_inst (
    .clk(clk), .rst_n(rst_n), .link_scl(scl), .sda_in(sda_line),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff),
    .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
    .select_strap_bit2(strap[2]), .program_timing_pin(tmg_pin),
    .ext_timing_en(ext_en), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .ew_busy_ff(ew_busy_ff),
    .sel_match_ff(sel_match_ff), .rd_dir_ff(rd_dir_ff), .addr_byte_ff(addr_byte_ff)
  );

  i2c_master_model i2c_master_model_inst (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );

  // compare and count
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // one addressed frame: start, address byte, stop
  task automatic test_addr(input logic [2:0] s, input logic [7:0] b, input logic hit);
    strap = s;
    repeat (10) @(negedge clk);
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(b, ack_n);
    check_val({7'h0, ack_n}, {7'h0, ~hit});
    check_val({7'h0, sel_match_ff}, {7'h0, hit});
    if (hit) check_val(addr_byte_ff, b);
    if (hit) check_val({7'h0, rd_dir_ff}, {7'h0, b[0]});
    i2c_master_model_inst.stop_cond();
  endtask : test_addr

  // single read, result one cycle later
  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    rd_addr = a;
    rd_req  = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
    check_val({7'h0, rd_valid_ff}, 8'h01);
    check_val(rd_data_ff, exp);
  endtask : read_chk

  // internally timed write at the top location; read and write refused while busy
  task automatic test_ew_internal();
    wr_addr = 8'hff;
    wr_data = 8'h5a;
    wr_req  = 1'b1;
    @(negedge clk);
    wr_data = 8'h3c;
    rd_addr = 8'hff;
    rd_req  = 1'b1;
    @(negedge clk);
    wr_req = 1'b0;
    rd_req = 1'b0;
    check_val({7'h0, rd_valid_ff}, 8'h00);
    n = 1;  // the refused cycle was already busy
    while (ew_busy_ff === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    check_val(n[7:0], 8'd20);
    read_chk(8'hff, 8'h5a);
  endtask : test_ew_internal

  // externally timed write; address refused while busy
  task automatic test_ew_external();
    ext_en = 1'b1;
    repeat (6) @(negedge clk);
    wr_addr = 8'h00;
    wr_data = 8'ha5;
    wr_req  = 1'b1;
    @(negedge clk);
    wr_req = 1'b0;
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte({DEV, strap, 1'b1}, ack_n);
    check_val({7'h0, ack_n}, 8'h01);
    i2c_master_model_inst.stop_cond();
    for (int i = 0; i < 3; i++) begin
      check_val({7'h0, ew_busy_ff}, 8'h01);
      tmg_pin = 1'b1;
      repeat (4) @(negedge clk);
      tmg_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    check_val({7'h0, ew_busy_ff}, 8'h00);
    ext_en = 1'b0;
    read_chk(8'h00, 8'ha5);
  endtask : test_ew_external

  // main sequence
  initial begin
    {rst_n, strap, tmg_pin, ext_en, wr_req, rd_req} = '0;
    {wr_addr, wr_data, rd_addr} = '0;
    error_cnt   = 0;
    comparisons = 0;
    repeat (12) @(negedge clk);
    check_val({4'h0, sda_oe_ff, ew_busy_ff, sel_match_ff, rd_valid_ff}, 8'h00);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    test_addr(3'b101, {DEV, 3'b101, 1'b1}, 1'b1);
    test_addr(3'b010, {DEV, 3'b010, 1'b0}, 1'b1);
    test_addr(3'b110, {DEV, 3'b011, 1'b0}, 1'b0);
    test_addr(3'b111, {4'h5, 3'b111, 1'b1}, 1'b0);
    test_addr(3'b111, {DEV, 3'b111, 1'b1}, 1'b1);
    test_ew_internal();
    test_ew_external();
    wrap_up();
  end

  // watchdog against a hung handshake
  initial begin
    #3_000_000;
    error_cnt++;
    wrap_up();
  end
endmodule : tb
